/* File: rtl/acmpc_pkg.sv */
package acmpc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_DEBUG_CTRL = 8'h09;
    localparam logic [7:0] ADDR_COMP_CTRL_BASE = 8'h10;
    localparam logic [7:0] ADDR_COMP_STATUS = 8'h20;
    localparam logic [7:0] DEBUG_CTRL_RESET = 8'h00;
    localparam logic [31:0] COMP_CTRL_RESET = 32'h0003_0000;
    // control field positions
    localparam int POS_ENABLE = 1;
    localparam int POS_SINGLE = 2;
    localparam int POS_START = 3;
    localparam int POS_SWAP = 15;
    localparam int POS_SPEED_LO = 16;
    localparam int POS_HYSTERESIS_LEVEL_ON = 19;
    localparam int POS_HYSTERESIS_LEVEL_LO = 20;
    localparam int POS_FILT_LO = 24;
    // filter codes
    localparam logic [2:0] FILT_OFF = 3'h0;
    localparam logic [2:0] FILT_MAJORITY_OF_THREE = 3'h1;
    localparam logic [2:0] FILT_MAJORITY_OF_FIVE = 3'h2;
    // cycles taken by one comparison
    localparam logic [3:0] COMPARE_CYCLES = 4'h4;
    typedef enum {ACMPC_IDLE, ACMPC_BUSY} acmpc_state_t;
endpackage

/* File: rtl/acmpc_chan_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface acmpc_chan_if;
    logic run;
    logic single;
    logic start;
    logic swap;
    logic [2:0] filt;
    logic raw_pos_gt_neg;
    logic result;
    logic busy;
    logic done;
    modport ctrl (output run, output single, output start, output swap, output filt,
        output raw_pos_gt_neg, input result, input busy, input done);
    modport chan (input run, input single, input start, input swap, input filt,
        input raw_pos_gt_neg, output result, output busy, output done);
endinterface
`default_nettype wire

/* File: rtl/acmpc_channel.sv */
`timescale 1ns/1ns
`default_nettype none
module acmpc_channel (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    acmpc_chan_if.chan ch
);
    acmpc_pkg::acmpc_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [3:0] hist, next_hist;
    logic result, next_result;
    logic done, next_done;
    logic sample;
    logic vote3, vote5;

    // swapped inputs give an inverted result
    assign sample = ch.raw_pos_gt_neg ^ ch.swap;
    // majority of the new sample and the latest two or four kept ones
    assign vote3 = (sample & hist[0]) | (sample & hist[1]) | (hist[0] & hist[1]);
    assign vote5 = ({2'h0, sample} + {2'h0, hist[0]} + {2'h0, hist[1]}
        + {2'h0, hist[2]} + {2'h0, hist[3]}) >= 3'h3;

    // comparison sequencer; a started comparison always finishes
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_hist = hist;
        next_result = result;
        next_done = 1'b0;
        unique case (state)
            acmpc_pkg::ACMPC_IDLE: begin
                if (ch.run && (ch.start || !ch.single)) begin
                    next_state = acmpc_pkg::ACMPC_BUSY;
                    next_cnt = acmpc_pkg::COMPARE_CYCLES;
                end
            end
            acmpc_pkg::ACMPC_BUSY: begin
                if (cnt == 4'h1) begin
                    next_state = acmpc_pkg::ACMPC_IDLE;
                    next_done = 1'b1;
                    next_hist = {hist[2:0], sample};
                    if (ch.filt == acmpc_pkg::FILT_MAJORITY_OF_THREE) begin
                        next_result = vote3;
                    end else if (ch.filt == acmpc_pkg::FILT_MAJORITY_OF_FIVE) begin
                        next_result = vote5;
                    end else begin
                        next_result = sample;
                    end
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= acmpc_pkg::ACMPC_IDLE;
            cnt <= 4'h0;
            hist <= 4'h0;
            result <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            hist <= next_hist;
            result <= next_result;
            done <= next_done;
        end
    end

    assign ch.result = result;
    assign ch.done = done;
    assign ch.busy = (state == acmpc_pkg::ACMPC_BUSY);
endmodule
`default_nettype wire

/* File: rtl/acmpc_top.sv */
// Summary of operation
// - debug_keep_running 0 and debugger halt: comparator unit stops.
// - a comparison in progress at halt entry still completes.
// - debug_keep_running 1: comparators keep running during debugger halt.
// - debug_keep_running at bit 0 survives software reset.
// - filter 0 none, 1 majority_of_three, 2 majority_of_five, 3..7 reserved.
// - hysteresis_level bits 21:20 act only while hysteresis_on set.
// - hysteresis applies only in continuous mode, single-shot bit 2 at 0.
// - hysteresis_on bit 19 turns hysteresis off at 0, on at 1.
// - swap bit 15 exchanges input selects and inverts the result.
// - hysteresis, speed and swap fields write directly, no synchronisation.
`timescale 1ns/1ns
`default_nettype none
module acmpc_top #(
    parameter int NUM_CHAN = 2
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic soft_rst_i,
    input wire logic debug_halt_i,
    input wire logic [NUM_CHAN-1:0] raw_compare_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [NUM_CHAN-1:0] result_o,
    output logic [NUM_CHAN-1:0] swap_inputs_o,
    output logic [NUM_CHAN-1:0] hysteresis_active_o,
    output logic [2*NUM_CHAN-1:0] hysteresis_level_o,
    output logic [2*NUM_CHAN-1:0] speed_o
);
    // debug control, cleared only by the system reset
    logic debug_keep_running, next_debug_keep_running;
    logic [31:0] rdata, next_rdata;
    logic halt_s1, halt_s2;
    logic [NUM_CHAN-1:0] raw_s1, raw_s2;
    logic [31:0] ctrl [NUM_CHAN];
    logic [31:0] next_ctrl [NUM_CHAN];
    logic [NUM_CHAN-1:0] res_w, busy_w, start_pend, next_start_pend;
    logic [NUM_CHAN-1:0] res_q, swap_q, hact_q;
    logic [2*NUM_CHAN-1:0] hlev_q, speed_q;
    logic unit_run;

    // two-stage synchronisers for pins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            halt_s1 <= 1'b0;
            halt_s2 <= 1'b0;
            raw_s1 <= '0;
            raw_s2 <= '0;
        end else begin
            halt_s1 <= debug_halt_i;
            halt_s2 <= halt_s1;
            raw_s1 <= raw_compare_i;
            raw_s2 <= raw_s1;
        end
    end

    // unit runs unless halted with keep-running clear
    assign unit_run = !halt_s2 || debug_keep_running;

    // debug register next value
    always_comb begin
        next_debug_keep_running = debug_keep_running;
        if (wr_i && addr_i == acmpc_pkg::ADDR_DEBUG_CTRL) begin
            next_debug_keep_running = wdata_i[0];
        end
    end

    // only the system reset clears it, soft reset leaves it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            debug_keep_running <= acmpc_pkg::DEBUG_CTRL_RESET[0];
        end else begin
            debug_keep_running <= next_debug_keep_running;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            acmpc_chan_if cif ();
            logic en;
            logic [31:0] wmask;
            logic wsel;

            assign en = ctrl[gi][acmpc_pkg::POS_ENABLE];
            assign wsel = wr_i && (addr_i == acmpc_pkg::ADDR_COMP_CTRL_BASE
                + 8'(4 * gi));

            // level, speed and swap locked while enabled
            always_comb begin
                wmask = 32'h0700_000e | 32'h0008_0000;
                if (!en) begin
                    wmask = wmask | 32'h0033_8000;
                end
            end

            // control register next value, written directly
            always_comb begin
                next_ctrl[gi] = ctrl[gi];
                next_start_pend[gi] = start_pend[gi];
                // the channel takes a pending start as it leaves idle
                if (start_pend[gi] && !busy_w[gi] && cif.run) begin
                    next_start_pend[gi] = 1'b0;
                end
                // a new start written in the same cycle wins over the take
                if (wsel) begin
                    next_ctrl[gi] = (ctrl[gi] & ~wmask) | (wdata_i & wmask);
                    next_ctrl[gi][acmpc_pkg::POS_START] = 1'b0;
                    if (wdata_i[acmpc_pkg::POS_START]) begin
                        next_start_pend[gi] = 1'b1;
                    end
                end
                if (!next_ctrl[gi][acmpc_pkg::POS_ENABLE]) begin
                    next_start_pend[gi] = 1'b0;
                end
            end

            always_ff @(posedge clk_i) begin
                if (sys_rst_i || soft_rst_i) begin
                    ctrl[gi] <= acmpc_pkg::COMP_CTRL_RESET;
                    start_pend[gi] <= 1'b0;
                end else begin
                    ctrl[gi] <= next_ctrl[gi];
                    start_pend[gi] <= next_start_pend[gi];
                end
            end

            assign cif.run = en && unit_run;
            assign cif.single = ctrl[gi][acmpc_pkg::POS_SINGLE];
            assign cif.start = start_pend[gi];
            assign cif.swap = ctrl[gi][acmpc_pkg::POS_SWAP];
            assign cif.filt = ctrl[gi][acmpc_pkg::POS_FILT_LO +: 3];
            assign cif.raw_pos_gt_neg = raw_s2[gi];
            assign res_w[gi] = cif.result;
            assign busy_w[gi] = cif.busy;

            acmpc_channel u_chan (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .ch(cif.chan)
            );

            // registered analog controls
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    res_q[gi] <= 1'b0;
                    swap_q[gi] <= 1'b0;
                    hact_q[gi] <= 1'b0;
                    hlev_q[2*gi +: 2] <= 2'h0;
                    speed_q[2*gi +: 2] <= 2'h0;
                end else begin
                    res_q[gi] <= res_w[gi];
                    swap_q[gi] <= ctrl[gi][acmpc_pkg::POS_SWAP];
                    hact_q[gi] <= ctrl[gi][acmpc_pkg::POS_HYSTERESIS_LEVEL_ON]
                        && !ctrl[gi][acmpc_pkg::POS_SINGLE];
                    hlev_q[2*gi +: 2] <= (ctrl[gi][acmpc_pkg::POS_HYSTERESIS_LEVEL_ON]
                        && !ctrl[gi][acmpc_pkg::POS_SINGLE])
                        ? ctrl[gi][acmpc_pkg::POS_HYSTERESIS_LEVEL_LO +: 2] : 2'h0;
                    speed_q[2*gi +: 2] <= ctrl[gi][acmpc_pkg::POS_SPEED_LO +: 2];
                end
            end
        end
    endgenerate

    // read mux, data valid one cycle after the strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd_i) begin
            if (addr_i == acmpc_pkg::ADDR_DEBUG_CTRL) begin
                next_rdata = {31'h0, debug_keep_running};
            end else if (addr_i == acmpc_pkg::ADDR_COMP_STATUS) begin
                next_rdata[NUM_CHAN-1:0] = res_w;
                next_rdata[8 +: NUM_CHAN] = busy_w;
            end
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (addr_i == acmpc_pkg::ADDR_COMP_CTRL_BASE + 8'(4 * i)) begin
                    next_rdata = ctrl[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign rdata_o = rdata;
    assign result_o = res_q;
    assign swap_inputs_o = swap_q;
    assign hysteresis_active_o = hact_q;
    assign hysteresis_level_o = hlev_q;
    assign speed_o = speed_q;
endmodule
`default_nettype wire

/* File: sim/acmpc_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module acmpc_chk #(
    parameter int NUM_CHAN = 2
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic soft_rst_i,
    input wire logic debug_halt_i,
    input wire logic [NUM_CHAN-1:0] raw_compare_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [NUM_CHAN-1:0] result_o,
    input wire logic [NUM_CHAN-1:0] swap_inputs_o,
    input wire logic [NUM_CHAN-1:0] hysteresis_active_o,
    input wire logic [2*NUM_CHAN-1:0] hysteresis_level_o,
    input wire logic [2*NUM_CHAN-1:0] speed_o
);
    logic keep, en0, raw_d, wr0, frozen, next_keep, next_en0;
    logic [31:0] last_w, next_last_w;
    logic [3:0] halt_n, run_n, next_halt_n, next_run_n;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // shadow debug bit, channel 0 control, halt and steady-input counters
    always_comb begin
        wr0 = wr_i && addr_i == 8'h10;
        frozen = debug_halt_i && !keep;
        next_keep = (wr_i && addr_i == 8'h09) ? wdata_i[0] : keep;
        next_en0 = soft_rst_i ? 1'b0 : (wr0 ? wdata_i[1] : en0);
        next_last_w = wr0 ? wdata_i : last_w;
        next_halt_n = frozen ? halt_n + {3'h0, halt_n != 4'hf} : 4'h0;
        next_run_n = (en0 && !frozen && !wr0 && last_w[26:24] == 3'h0 && !last_w[2]
            && raw_compare_i[0] == raw_d) ? run_n + {3'h0, run_n != 4'hf} : 4'h0;
    end
    always_ff @(posedge clk_i) begin
        keep <= sys_rst_i ? 1'b0 : next_keep;
        en0 <= sys_rst_i ? 1'b0 : next_en0;
        last_w <= next_last_w;
        halt_n <= sys_rst_i ? 4'h0 : next_halt_n;
        run_n <= sys_rst_i ? 4'h0 : next_run_n;
        raw_d <= raw_compare_i[0];
    end
    a_field_write: assert property (wr0 && !en0 |-> ##[1:2]
        (swap_inputs_o[0] == last_w[15] && speed_o[1:0] == last_w[17:16]
        && hysteresis_active_o[0] == (last_w[19] && !last_w[2])
        && hysteresis_level_o[1:0] == ((last_w[19] && !last_w[2]) ? last_w[21:20] : 2'h0)))
        else $error("channel 0 fields do not follow a write");
    a_locked_fields: assert property (wr0 && en0 |=>
        ($stable(swap_inputs_o[0]) && $stable(speed_o[1:0])
        && (!$stable(hysteresis_active_o[0]) || $stable(hysteresis_level_o[1:0])))[*2])
        else $error("locked field changed while enabled");
    a_hysteresis_level_gate: assert property (hysteresis_level_o[1:0] != 2'h0 |-> hysteresis_active_o[0])
        else $error("level shown while hysteresis off");
    a_halt_freeze: assert property (halt_n == 4'hf |-> $stable(result_o))
        else $error("result moved during debugger halt");
    a_keep_follow: assert property (run_n == 4'hf |-> result_o[0] == (raw_d ^ swap_inputs_o[0]))
        else $error("result does not follow input");
    a_debug_read: assert property (rd_i && addr_i == 8'h09 |=> rdata_o == {31'h0, keep})
        else $error("debug bit read back wrong");
    a_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside answer cycle");
    a_speed_reset: assert property ($fell(sys_rst_i) |-> ##[1:2] speed_o == {NUM_CHAN{2'h3}})
        else $error("speed not at reset value");
    a_soft_reset: assert property (soft_rst_i |-> ##[1:2] swap_inputs_o == '0
        && speed_o == {NUM_CHAN{2'h3}} && hysteresis_active_o == '0)
        else $error("soft reset left channel fields");
endmodule
`default_nettype wire

/* File: sim/comparator_control_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module comparator_control_tb_top;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, soft_rst_i = 1'b0, debug_halt_i = 1'b0;
    logic wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0, seen;
    logic [1:0] raw_compare_i = 2'h0, result_o, swap_inputs_o, hysteresis_active_o;
    logic [3:0] hysteresis_level_o, speed_o;
    logic [7:0] addr_i = 8'h0, a;
    logic [31:0] wdata_i = 32'h0, rdata_o, v, r;
    logic [31:0] q[$];
    int n_errors = 0, compares = 0, cycles = 0;
    acmpc_top #(.NUM_CHAN(2)) u_acmpc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .soft_rst_i(soft_rst_i), .debug_halt_i(debug_halt_i), .raw_compare_i(raw_compare_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .result_o(result_o), .swap_inputs_o(swap_inputs_o),
        .hysteresis_active_o(hysteresis_active_o),
        .hysteresis_level_o(hysteresis_level_o), .speed_o(speed_o));
    always #50 clk_i = ~clk_i;
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= ad;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        q.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // hold the input steady, then compare the filtered result
    task automatic settle(input logic in, input logic e);
        @(posedge clk_i);
        raw_compare_i[0] <= in;
        repeat (40) @(posedge clk_i);
        @(negedge clk_i);
        chk("result", {31'h0, e}, {31'h0, result_o[0]});
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
    endtask
    function automatic logic [31:0] cw(logic en, logic one, logic sw, logic hon,
        logic [1:0] lv, logic [2:0] f);
        return {5'h0, f, 2'h0, lv, hon, 1'b0, 2'h3, sw, 12'h0, one, en, 1'b0};
    endfunction
    // read answers, channel 1 noise and the run limit
    always @(posedge clk_i) begin
        rd_q <= rd_i;
        cycles <= cycles + 1;
        raw_compare_i[1] <= 1'($urandom);
        if (cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
    end
    always @(negedge clk_i) if (rd_q) chk("rdata", q.pop_front(), rdata_o);
    initial begin
        void'($urandom(32'heb5cb1af));
        do_reset();
        rd(8'h09, 32'h0);
        rd(8'h10, 32'h0003_0000);
        rd(8'h40, 32'h0);
        repeat (6) begin
            a = 8'h10 + 8'(4 * $urandom_range(1));
            r = $urandom;
            v = cw(1'b0, r[0], r[1], r[2], r[4:3], r[7:5]);
            wr(a, v);
            rd(a, v);
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h10, cw(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 3'(c)));
            wr(8'h10, cw(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 3'(c)));
            settle(1'b0, 1'b0);
            @(posedge clk_i);
            raw_compare_i[0] <= 1'b1;
            repeat (3) @(posedge clk_i);
            raw_compare_i[0] <= 1'b0;
            seen = 1'b0;
            repeat (30) begin
                @(negedge clk_i);
                seen = seen | result_o[0];
            end
            if (c == 1 || c == 2) chk("glitch", 32'h0, {31'h0, seen});
            settle(1'b1, 1'b1);
        end
        wr(8'h10, cw(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 3'h0));
        wr(8'h10, cw(1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 3'h0));
        settle(1'b1, 1'b0);
        settle(1'b0, 1'b1);
        wr(8'h10, cw(1'b1, 1'b0, 1'b0, 1'b1, 2'h2, 3'h0) ^ 32'h0001_0000);
        rd(8'h10, cw(1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 3'h0));
        wr(8'h09, 32'h0);
        @(posedge clk_i);
        debug_halt_i <= 1'b1;
        settle(1'b0, 1'b1);
        settle(1'b1, 1'b1);
        @(posedge clk_i);
        debug_halt_i <= 1'b0;
        settle(1'b1, 1'b0);
        wr(8'h09, 32'h1);
        @(posedge clk_i);
        debug_halt_i <= 1'b1;
        settle(1'b0, 1'b1);
        @(posedge clk_i);
        soft_rst_i <= 1'b1;
        @(posedge clk_i);
        soft_rst_i <= 1'b0;
        rd(8'h09, 32'h1);
        rd(8'h10, 32'h0003_0000);
        do_reset();
        rd(8'h09, 32'h0);
        // single-shot: nothing moves until a start is written
        debug_halt_i <= 1'b0;
        wr(8'h10, cw(1'b1, 1'b1, 1'b0, 1'b1, 2'h1, 3'h0));
        settle(1'b1, 1'b0);
        wr(8'h10, cw(1'b1, 1'b1, 1'b0, 1'b1, 2'h1, 3'h0) | 32'h0000_0008);
        settle(1'b1, 1'b1);
        rd(8'h20, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        give_verdict();
    end
endmodule
bind acmpc_top acmpc_chk #(.NUM_CHAN(NUM_CHAN)) u_acmpc_chk (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i), .debug_halt_i(debug_halt_i),
    .raw_compare_i(raw_compare_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .result_o(result_o), .swap_inputs_o(swap_inputs_o),
    .hysteresis_active_o(hysteresis_active_o), .hysteresis_level_o(hysteresis_level_o),
    .speed_o(speed_o));
`default_nettype wire
